/* File: rtl/fsrc_cfg.svh */
// opcodes, frame lengths and timing counts of the command interpreter
`ifndef FSRC_CFG_SVH
`define FSRC_CFG_SVH

// commands gated by the suspend latency
`define FSRC_OP_READ      8'h03
`define FSRC_OP_READ4     8'h13
`define FSRC_OP_FREAD     8'h0B
`define FSRC_OP_FREAD4    8'h0C
`define FSRC_OP_OREAD     8'hEC
`define FSRC_OP_ODTRD     8'hEE
`define FSRC_OP_SFDP      8'h5A
`define FSRC_OP_IDREAD    8'h9F
`define FSRC_OP_BURSTLEN  8'hC0
`define FSRC_OP_OTPENTER  8'hB1
`define FSRC_OP_OTPEXIT   8'hC1
`define FSRC_OP_WRITE_ENABLE_COMMAND      8'h06
`define FSRC_OP_RESUME    8'h30
`define FSRC_OP_LOCKRD    8'h2D
`define FSRC_OP_SPBRD     8'hE2
`define FSRC_OP_FBRD      8'h16
`define FSRC_OP_DPBRD     8'hE0
`define FSRC_OP_CFG2RD    8'h71
`define FSRC_OP_CFG2WR    8'h72
// commands accepted at any time during suspend
`define FSRC_OP_WRITE_DISABLE_COMMAND      8'h04
`define FSRC_OP_SRREAD    8'h05
`define FSRC_OP_CRREAD    8'h15
`define FSRC_OP_SECREAD   8'h2B
`define FSRC_OP_RESREAD   8'hAB
`define FSRC_OP_ARM       8'h66
`define FSRC_OP_EXEC      8'h99
`define FSRC_OP_NOP       8'h00

// frame shape of the parameter-table read
`define FSRC_SPI_OPC_BITS   5'd8
`define FSRC_SPI_ADDR_BITS  5'd24
`define FSRC_SPI_DUMMY      5'd8
`define FSRC_OCT_ADDR_BYTES 5'd4
`define FSRC_OCT_DUMMY      5'd20
`define FSRC_SO_LINE_OE     8'h02

// suspend latency: figure in ns, cycles rounded up at 4 ns
`define FSRC_CLK_PERIOD_NS  4
`define FSRC_SUSP_LAT_NS    20000
`define FSRC_SUSP_LAT_CYC \
   ((`FSRC_SUSP_LAT_NS + `FSRC_CLK_PERIOD_NS - 1) / `FSRC_CLK_PERIOD_NS)

`endif

/* File: rtl/fsrc_pkg.sv */
// state types of the command interpreter
package fsrc_pkg;

   typedef enum logic [5:0] {
      L_OPC   = 6'b00_0001,
      L_OPC2  = 6'b00_0010,
      L_ADDR  = 6'b00_0100,
      L_DUMMY = 6'b00_1000,
      L_DATA  = 6'b01_0000,
      L_SKIP  = 6'b10_0000
   } fsrc_link_t;

   typedef enum logic [3:0] {
      OP_IDLE   = 4'b0001,
      OP_BUSY   = 4'b0010,
      OP_SUSPNG = 4'b0100,
      OP_SUSP   = 4'b1000
   } fsrc_op_t;

endpackage

/* File: rtl/fsrc_cmd.sv */
// suspend, resume, reset and parameter-table command interpreter
//
// Summary of operation
// RL1 - latency commands accepted only after suspend latency
// RL2 - status, security, reset accepted anytime in suspend
// RL3 - resume sets write latch, busy; clears flags
// RL4 - resumed operation runs until done or suspended
// RL5 - host waits resume-to-suspend time before suspending
// RL6 - host waits cycle time after resume
// RL7 - completion clears write latch and busy
// RL8 - no-operation only cancels a pending arm
// RL9 - arm then execute restores power-on defaults
// RL10 - execute works only right after arm
// RL11 - software reset aborts program or erase
// RL12 - host waits recovery time after reset
// RL13 - single-line table read: 3 address, 8 dummy
// RL14 - octal table read: 4 address, 20 dummy
// RL15 - host gives even address in double rate
// RL16 - software reset clears error-correction status
// RL17 - suspend sets program or erase suspended flag
// RL18 - suspend entry clears write latch, becomes ready
// RL19 - unlisted commands ignored while suspended
`timescale 1ns/100ps
`include "fsrc_cfg.svh"

module fsrc_cmd
   import fsrc_pkg::*;
#(
   parameter int SUSP_LAT_CYC = `FSRC_SUSP_LAT_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // link pins
   input  wire logic       csN,
   input  wire logic       sclk,
   input  wire logic [7:0] dataIn,
   output logic      [7:0] dataOut,
   output logic      [7:0] dataOe,
   // configuration
   input  wire logic       octalMode,
   // array core
   input  wire logic       progStart,
   input  wire logic       eraseStart,
   input  wire logic       suspendReq,
   input  wire logic       opDone,
   // status
   output logic            writeEnableLatch,
   output logic            writeInProgress,
   output logic            programSuspendedFlag,
   output logic            eraseSuspendedFlag,
   output logic            resetArmed,
   output logic            arrayRun,
   // events
   output logic            cmdValid,
   output logic            cmdIgnored,
   output logic      [7:0] cmdCode,
   output logic            softReset,
   output logic            opAbort,
   output logic            eccStatusClear
);

   localparam logic [7:0] TBL [16] = '{
      8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h00, 8'hFF,
      8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hFF};

   function automatic logic isLatencyCmd(input logic [7:0] op);
      case (op)
         `FSRC_OP_READ, `FSRC_OP_READ4, `FSRC_OP_FREAD, `FSRC_OP_FREAD4,
         `FSRC_OP_OREAD, `FSRC_OP_ODTRD, `FSRC_OP_SFDP, `FSRC_OP_IDREAD,
         `FSRC_OP_BURSTLEN, `FSRC_OP_OTPENTER, `FSRC_OP_OTPEXIT,
         `FSRC_OP_WRITE_ENABLE_COMMAND, `FSRC_OP_RESUME, `FSRC_OP_LOCKRD, `FSRC_OP_SPBRD,
         `FSRC_OP_FBRD, `FSRC_OP_DPBRD, `FSRC_OP_CFG2RD,
         `FSRC_OP_CFG2WR: isLatencyCmd = 1'b1;
         default: isLatencyCmd = 1'b0;
      endcase
   endfunction

   function automatic logic isAnytimeCmd(input logic [7:0] op);
      case (op)
         `FSRC_OP_WRITE_DISABLE_COMMAND, `FSRC_OP_SRREAD, `FSRC_OP_CRREAD, `FSRC_OP_SECREAD,
         `FSRC_OP_RESREAD, `FSRC_OP_ARM, `FSRC_OP_EXEC,
         `FSRC_OP_NOP: isAnytimeCmd = 1'b1;
         default: isAnytimeCmd = 1'b0;
      endcase
   endfunction

   // RL1 RL2 RL19 acceptance by state
   function automatic logic cmdAllowed(input logic [7:0] op,
                                       input fsrc_op_t   st);
      case (st)
         OP_IDLE:   cmdAllowed = 1'b1;
         OP_BUSY:   cmdAllowed = isAnytimeCmd(op);
         OP_SUSPNG: cmdAllowed = isAnytimeCmd(op);
         OP_SUSP:   cmdAllowed = isLatencyCmd(op) | isAnytimeCmd(op);
         default:   cmdAllowed = 1'b0;
      endcase
   endfunction

   logic        rstS1;
   logic        rstN;
   logic        cs1, cs2, cs3;
   logic        sck1, sck2, sck3;
   logic [7:0]  din1, din2;
   logic        sckRise, sckFall;
   fsrc_link_t  lnk_r;
   fsrc_op_t    opSt_r;
   logic [4:0]  cnt_r;
   logic [7:0]  sh_r;
   logic [31:0] addr_r;
   logic [3:0]  ptr_r;
   logic [2:0]  bitIdx_r;
   logic        cmdHit_r;
   logic        cmdAcc_r;
   logic [7:0]  cmdOp_r;
   logic        isErase_r;
   logic [15:0] latCnt_r;
   logic [7:0]  spiOp;
   logic        doExec;
   logic        latDone;

   // reset release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstS1 <= 1'b0;
         rstN  <= 1'b0;
      end else begin
         rstS1 <= 1'b1;
         rstN  <= rstS1;
      end
   end

   // pin synchronisers
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         {cs1, cs2, cs3}    <= 3'b111;
         {sck1, sck2, sck3} <= 3'b000;
         din1               <= 8'h00;
         din2               <= 8'h00;
      end else begin
         {cs1, cs2, cs3}    <= {csN, cs1, cs2};
         {sck1, sck2, sck3} <= {sclk, sck1, sck2};
         din1               <= dataIn;
         din2               <= din1;
      end
   end

   assign sckRise = sck2 & ~sck3;
   assign sckFall = ~sck2 & sck3;
   assign spiOp   = {sh_r[6:0], din2[0]};
   assign doExec  = cmdHit_r & cmdAcc_r & (cmdOp_r == `FSRC_OP_EXEC) &
                    resetArmed;
   assign latDone = (latCnt_r == 16'(SUSP_LAT_CYC - 1));
   assign arrayRun = (opSt_r == OP_BUSY);

   // link framing: opcode, address, dummy, data
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         lnk_r    <= L_OPC;
         cnt_r    <= 5'd0;
         sh_r     <= 8'h00;
         addr_r   <= 32'h0000_0000;
         cmdHit_r <= 1'b0;
         cmdAcc_r <= 1'b0;
         cmdOp_r  <= 8'h00;
      end else begin
         cmdHit_r <= 1'b0;
         if (cs2) begin
            lnk_r <= L_OPC;
            cnt_r <= 5'd0;
         end else if (sckRise) begin
            case (lnk_r)
               L_OPC: begin
                  if (octalMode) begin
                     sh_r  <= din2;
                     lnk_r <= L_OPC2;
                  end else if (cnt_r == `FSRC_SPI_OPC_BITS - 5'd1) begin
                     cmdHit_r <= 1'b1;
                     cmdOp_r  <= spiOp;
                     cmdAcc_r <= cmdAllowed(spiOp, opSt_r);
                     cnt_r    <= 5'd0;
                     // RL13 single-line table read
                     lnk_r <= (spiOp == `FSRC_OP_SFDP &&
                               cmdAllowed(spiOp, opSt_r)) ? L_ADDR : L_SKIP;
                  end else begin
                     sh_r  <= spiOp;
                     cnt_r <= cnt_r + 5'd1;
                  end
               end
               L_OPC2: begin
                  cnt_r <= 5'd0;
                  if (din2 == ~sh_r) begin
                     cmdHit_r <= 1'b1;
                     cmdOp_r  <= sh_r;
                     cmdAcc_r <= cmdAllowed(sh_r, opSt_r);
                     // RL14 octal table read
                     lnk_r <= (sh_r == `FSRC_OP_SFDP &&
                               cmdAllowed(sh_r, opSt_r)) ? L_ADDR : L_SKIP;
                  end else begin
                     lnk_r <= L_SKIP;
                  end
               end
               L_ADDR: begin
                  cnt_r <= cnt_r + 5'd1;
                  if (octalMode) begin
                     addr_r <= {addr_r[23:0], din2};
                     if (cnt_r == `FSRC_OCT_ADDR_BYTES - 5'd1) begin
                        lnk_r <= L_DUMMY;
                        cnt_r <= 5'd0;
                     end
                  end else begin
                     addr_r <= {addr_r[30:0], din2[0]};
                     if (cnt_r == `FSRC_SPI_ADDR_BITS - 5'd1) begin
                        lnk_r <= L_DUMMY;
                        cnt_r <= 5'd0;
                     end
                  end
               end
               L_DUMMY: begin
                  cnt_r <= cnt_r + 5'd1;
                  if (cnt_r == (octalMode ? `FSRC_OCT_DUMMY - 5'd1
                                          : `FSRC_SPI_DUMMY - 5'd1)) begin
                     lnk_r <= L_DATA;
                  end
               end
               L_DATA: lnk_r <= L_DATA;
               L_SKIP: lnk_r <= L_SKIP;
               default: lnk_r <= L_SKIP;
            endcase
         end
      end
   end

   // table data driven on falling edges until chip select rises
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         dataOut  <= 8'h00;
         dataOe   <= 8'h00;
         ptr_r    <= 4'h0;
         bitIdx_r <= 3'd0;
      end else if (cs2 || lnk_r != L_DATA) begin
         dataOe   <= 8'h00;
         ptr_r    <= addr_r[3:0];
         bitIdx_r <= 3'd0;
      end else if (sckFall) begin
         if (octalMode) begin
            dataOut <= TBL[ptr_r];
            dataOe  <= 8'hFF;
            ptr_r   <= ptr_r + 4'h1;
         end else begin
            dataOut  <= {6'd0, TBL[ptr_r][3'd7 - bitIdx_r], 1'b0};
            dataOe   <= `FSRC_SO_LINE_OE;
            bitIdx_r <= bitIdx_r + 3'd1;
            if (bitIdx_r == 3'd7) begin
               ptr_r <= ptr_r + 4'h1;
            end
         end
      end
   end

   // reset arming
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         resetArmed <= 1'b0;
      end else if (cmdHit_r) begin
         // RL8 RL10 any other opcode disarms
         resetArmed <= cmdAcc_r & (cmdOp_r == `FSRC_OP_ARM);
      end
   end

   // operation state, latch and suspend flags
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         opSt_r               <= OP_IDLE;
         writeEnableLatch     <= 1'b0;
         writeInProgress      <= 1'b0;
         programSuspendedFlag <= 1'b0;
         eraseSuspendedFlag   <= 1'b0;
         isErase_r            <= 1'b0;
         latCnt_r             <= 16'h0000;
      end else if (doExec) begin
         // RL9 RL11 defaults restored, operation dropped
         opSt_r               <= OP_IDLE;
         writeEnableLatch     <= 1'b0;
         writeInProgress      <= 1'b0;
         programSuspendedFlag <= 1'b0;
         eraseSuspendedFlag   <= 1'b0;
         latCnt_r             <= 16'h0000;
      end else begin
         if (cmdHit_r && cmdAcc_r && cmdOp_r == `FSRC_OP_WRITE_ENABLE_COMMAND) begin
            writeEnableLatch <= 1'b1;
         end
         if (cmdHit_r && cmdAcc_r && cmdOp_r == `FSRC_OP_WRITE_DISABLE_COMMAND) begin
            writeEnableLatch <= 1'b0;
         end
         case (opSt_r)
            OP_IDLE: begin
               if ((progStart || eraseStart) && writeEnableLatch) begin
                  opSt_r          <= OP_BUSY;
                  writeInProgress <= 1'b1;
                  isErase_r       <= eraseStart;
               end
            end
            OP_BUSY: begin
               // RL4 run to completion or suspend
               if (opDone) begin
                  // RL7 completion clears latch and busy
                  opSt_r           <= OP_IDLE;
                  writeEnableLatch <= 1'b0;
                  writeInProgress  <= 1'b0;
               end else if (suspendReq) begin
                  opSt_r   <= OP_SUSPNG;
                  latCnt_r <= 16'h0000;
               end
            end
            OP_SUSPNG: begin
               latCnt_r <= latCnt_r + 16'h0001;
               if (latDone) begin
                  // RL17 RL18 flag set, latch cleared, ready
                  opSt_r               <= OP_SUSP;
                  writeEnableLatch     <= 1'b0;
                  writeInProgress      <= 1'b0;
                  programSuspendedFlag <= ~isErase_r;
                  eraseSuspendedFlag   <= isErase_r;
               end
            end
            OP_SUSP: begin
               // RL1 RL3 resume after latency
               if (cmdHit_r && cmdAcc_r && cmdOp_r == `FSRC_OP_RESUME) begin
                  opSt_r               <= OP_BUSY;
                  writeEnableLatch     <= 1'b1;
                  writeInProgress      <= 1'b1;
                  programSuspendedFlag <= 1'b0;
                  eraseSuspendedFlag   <= 1'b0;
               end
            end
            default: opSt_r <= OP_IDLE;
         endcase
      end
   end

   // command events
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         cmdValid       <= 1'b0;
         cmdIgnored     <= 1'b0;
         cmdCode        <= 8'h00;
         softReset      <= 1'b0;
         opAbort        <= 1'b0;
         eccStatusClear <= 1'b0;
      end else begin
         cmdValid   <= cmdHit_r & cmdAcc_r;
         // RL19 unlisted opcodes only reported
         cmdIgnored <= cmdHit_r & ~cmdAcc_r;
         if (cmdHit_r) begin
            cmdCode <= cmdOp_r;
         end
         softReset      <= doExec;
         // RL11 abort of program or erase
         opAbort        <= doExec & (opSt_r != OP_IDLE);
         // RL16 error-correction status cleared
         eccStatusClear <= doExec;
      end
   end

   chk_resume_sets: assert property ( // RL3
      @(posedge clk) disable iff (!rstN)
      (opSt_r == OP_SUSP && cmdHit_r && cmdAcc_r &&
       cmdOp_r == `FSRC_OP_RESUME)
      |=> writeEnableLatch && writeInProgress &&
          !programSuspendedFlag && !eraseSuspendedFlag && arrayRun)
      else $error("resume did not restore busy state");

   chk_done_clears: assert property ( // RL7
      @(posedge clk) disable iff (!rstN)
      (opSt_r == OP_BUSY && opDone && !doExec)
      |=> !writeEnableLatch && !writeInProgress)
      else $error("completion left latch or busy set");

   chk_exec_unarmed: assert property ( // RL10
      @(posedge clk) disable iff (!rstN)
      (cmdHit_r && cmdOp_r == `FSRC_OP_EXEC && !resetArmed)
      |=> !softReset)
      else $error("execute without arm reset the device");

   chk_reset_defaults: assert property ( // RL9
      @(posedge clk) disable iff (!rstN)
      doExec |=> !writeEnableLatch && !writeInProgress &&
                 !programSuspendedFlag && !eraseSuspendedFlag &&
                 opSt_r == OP_IDLE ##0 softReset && eccStatusClear)
      else $error("software reset left state behind");

   chk_nop_cancels: assert property ( // RL8
      @(posedge clk) disable iff (!rstN)
      (cmdHit_r && cmdOp_r == `FSRC_OP_NOP)
      |=> !resetArmed && writeEnableLatch == $past(writeEnableLatch))
      else $error("no-operation misbehaved");

   chk_susp_entry: assert property ( // RL17
      @(posedge clk) disable iff (!rstN)
      (opSt_r == OP_SUSPNG && latDone && !doExec)
      |=> (programSuspendedFlag ^ eraseSuspendedFlag) &&
          !writeEnableLatch && !writeInProgress)
      else $error("suspend entry did not set flag");

   chk_ignored_keeps: assert property ( // RL19
      @(posedge clk) disable iff (!rstN)
      (opSt_r == OP_SUSP && cmdHit_r && !cmdAcc_r)
      |=> opSt_r == OP_SUSP &&
          programSuspendedFlag == $past(programSuspendedFlag) &&
          eraseSuspendedFlag == $past(eraseSuspendedFlag))
      else $error("ignored command changed suspend state");

   chk_latency_gate: assert property ( // RL1
      @(posedge clk) disable iff (!rstN)
      (cmdHit_r && opSt_r == OP_SUSPNG && isLatencyCmd(cmdOp_r))
      |=> cmdIgnored && !cmdValid)
      else $error("latency command accepted too early");

   chk_anytime_ok: assert property ( // RL2
      @(posedge clk) disable iff (!rstN)
      (cmdHit_r && opSt_r != OP_IDLE &&
       (cmdOp_r == `FSRC_OP_SRREAD || cmdOp_r == `FSRC_OP_SECREAD))
      |=> cmdValid)
      else $error("status read refused during operation");

   chk_abort_flag: assert property ( // RL11
      @(posedge clk) disable iff (!rstN)
      (doExec && opSt_r == OP_BUSY) |=> opAbort && !arrayRun)
      else $error("reset during operation not aborted");

   chk_sfdp_spi_oe: assert property ( // RL13
      @(posedge clk) disable iff (!rstN)
      (lnk_r == L_DATA && sckFall && !cs2 && !octalMode)
      |=> dataOe == `FSRC_SO_LINE_OE)
      else $error("single-line data not on output line");

endmodule // fsrc_cmd

/* File: bench/fsrc_host_model.sv */
// host flash controller model driving the link pins
`timescale 1ns/100ps

module fsrc_host_model (
   // clock
   input  wire logic       clk,
   // link pins
   output logic            csN,
   output logic            sclk,
   output logic      [7:0] dataIn,
   input  wire logic [7:0] dataOut,
   input  wire logic [7:0] dataOe
);
   logic [7:0] q;
   logic [7:0] oe;

   initial begin
      csN    = 1'b1;
      sclk   = 1'b0;
      dataIn = 8'h00;
      q      = 8'h00;
      oe     = 8'h00;
   end

   // one link bit: 36 ns low, 32 ns high
   task automatic tick(input logic [7:0] d);
      @(posedge clk) #1;
      dataIn = d;
      repeat (8) @(posedge clk);
      #1 q = dataOut;
      oe   = dataOe;
      sclk = 1'b1;
      repeat (8) @(posedge clk);
      #1 sclk = 1'b0;
   endtask

   // whole frame: opcode, address, dummy, read
   task automatic frame(input logic oct, input logic [7:0] opc,
                        input int nAddr, input int nDum, input int nRd,
                        output logic [31:0] rd);
      rd = 32'h0000_0000;
      @(posedge clk) #1 csN = 1'b0;
      if (oct) begin
         tick(opc);
         tick(~opc);
      end else begin
         for (int i = 7; i >= 0; i--) tick({~dataIn[7:1], opc[i]});
      end
      for (int i = 0; i < nAddr; i++) tick(8'h00);
      for (int i = 0; i < nDum; i++) tick(~dataIn);
      for (int i = 0; i < nRd; i++) begin
         tick(~dataIn);
         rd = oct ? {rd[23:0], q} : {rd[30:0], q[1]};
      end
      @(posedge clk) #1 csN = 1'b1;
      dataIn = ~dataIn;
      repeat (12) @(posedge clk);
   endtask
endmodule // fsrc_host_model

/* File: bench/test_flash_suspend_resume_reset_cmds.sv */
// self-checking testbench of the command interpreter
`timescale 1ns/100ps

`define CHECK(what, exp, got) \
   begin \
      checkCount++; \
      if ((got) !== (exp)) begin \
         errCount++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end

module test_flash_suspend_resume_reset_cmds;
   localparam int LAT = 400;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic csN, sclk;
   logic [7:0] dataIn, dataOut, dataOe, cmdCode;
   logic octalMode = 1'b0;
   logic progStart = 1'b0;
   logic eraseStart = 1'b0;
   logic suspendReq = 1'b0;
   logic opDone = 1'b0;
   logic write_enable_latch, write_in_progress, progFlag, eraseFlag, resetArmed, arrayRun;
   logic cmdValid, cmdIgnored, softReset, opAbort, eccClear;
   int errCount = 0;
   int checkCount = 0;
   int validCnt = 0, ignCnt = 0, rstCnt = 0, eccCnt = 0, abortCnt = 0;

   always #2 clk = ~clk;

   fsrc_cmd #(.SUSP_LAT_CYC(LAT)) fsrc_cmd_inst (
      .clk(clk), .nrst(nrst), .csN(csN), .sclk(sclk), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe), .octalMode(octalMode),
      .progStart(progStart), .eraseStart(eraseStart),
      .suspendReq(suspendReq), .opDone(opDone),
      .writeEnableLatch(write_enable_latch), .writeInProgress(write_in_progress),
      .programSuspendedFlag(progFlag), .eraseSuspendedFlag(eraseFlag),
      .resetArmed(resetArmed), .arrayRun(arrayRun), .cmdValid(cmdValid),
      .cmdIgnored(cmdIgnored), .cmdCode(cmdCode), .softReset(softReset),
      .opAbort(opAbort), .eccStatusClear(eccClear));

   fsrc_host_model fsrc_host_model_inst (
      .clk(clk), .csN(csN), .sclk(sclk), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe));

   // event pulse counters
   always @(posedge clk) begin
      validCnt += (cmdValid === 1'b1);
      ignCnt   += (cmdIgnored === 1'b1);
      rstCnt   += (softReset === 1'b1);
      eccCnt   += (eccClear === 1'b1);
      abortCnt += (opAbort === 1'b1);
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic op(input logic [7:0] c);
      logic [31:0] rd;
      fsrc_host_model_inst.frame(1'b0, c, 0, 0, 0, rd);
   endtask

   // 0 program, 1 erase, 2 suspend, 3 done
   task automatic pulse(input int which);
      @(posedge clk) #1;
      case (which)
         0: progStart = 1'b1;
         1: eraseStart = 1'b1;
         2: suspendReq = 1'b1;
         default: opDone = 1'b1;
      endcase
      @(posedge clk) #1;
      {progStart, eraseStart, suspendReq, opDone} = 4'b0000;
      repeat (3) @(posedge clk);
   endtask

   task automatic testResetState();
      `CHECK("wel", 1'b0, write_enable_latch)
      `CHECK("wip", 1'b0, write_in_progress)
      `CHECK("flags", 2'b00, {progFlag, eraseFlag})
      `CHECK("dataOe idle", 8'h00, dataOe)
   endtask

   task automatic testTable(input logic oct);
      logic [31:0] rd;
      int v0;
      v0 = validCnt;
      @(posedge clk) #1 octalMode = oct;
      if (oct)
         fsrc_host_model_inst.frame(1'b1, 8'h5A, 4, 20, 4, rd);
      else
         fsrc_host_model_inst.frame(1'b0, 8'h5A, 24, 8, 32, rd);
      `CHECK("table data", 32'h5346_4450, rd)
      `CHECK("oe data", oct ? 8'hFF : 8'h02, fsrc_host_model_inst.oe)
      `CHECK("oe after cs", 8'h00, dataOe)
      `CHECK("cmdCode", 8'h5A, cmdCode)
      `CHECK("valid pulses", v0 + 1, validCnt)
      @(posedge clk) #1 octalMode = 1'b0;
   endtask

   task automatic testSuspend(input logic isErase);
      int v0, i0;
      v0 = validCnt;
      i0 = ignCnt;
      op(8'h06);
      `CHECK("wel after enable", 1'b1, write_enable_latch)
      pulse(isErase ? 1 : 0);
      `CHECK("run", 2'b11, {write_in_progress, arrayRun})
      pulse(2);
      op(8'h05);
      `CHECK("anytime accepted", v0 + 2, validCnt)
      op(8'h03);
      `CHECK("early read refused", i0 + 1, ignCnt)
      repeat (LAT) @(posedge clk);
      `CHECK("flags", {~isErase, isErase}, {progFlag, eraseFlag})
      `CHECK("wel in suspend", 1'b0, write_enable_latch)
      op(8'h06);
      `CHECK("wel after latency", 1'b1, write_enable_latch)
      op(8'h04);
      `CHECK("wel after disable", 1'b0, write_enable_latch)
      op(8'hD8);
      `CHECK("unlisted refused", i0 + 2, ignCnt)
      `CHECK("flags kept", {~isErase, isErase}, {progFlag, eraseFlag})
      op(8'h30);
      `CHECK("resume", 4'b1100, {write_enable_latch, write_in_progress, progFlag, eraseFlag})
      `CHECK("run again", 1'b1, arrayRun)
      pulse(3);
      `CHECK("done", 3'b000, {write_enable_latch, write_in_progress, arrayRun})
   endtask

   task automatic testSoftReset();
      int r0, a0, e0;
      r0 = rstCnt;
      a0 = abortCnt;
      e0 = eccCnt;
      op(8'h06);
      pulse(0);
      op(8'h66);
      `CHECK("armed", 1'b1, resetArmed)
      op(8'h00);
      `CHECK("disarmed", 1'b0, resetArmed)
      `CHECK("op untouched", 2'b11, {write_in_progress, arrayRun})
      op(8'h99);
      `CHECK("lone execute", r0, rstCnt)
      op(8'h66);
      op(8'h99);
      `CHECK("reset pulse", r0 + 1, rstCnt)
      `CHECK("ecc clear", e0 + 1, eccCnt)
      `CHECK("abort", a0 + 1, abortCnt)
      `CHECK("defaults", 4'b0000, {write_enable_latch, write_in_progress, arrayRun, resetArmed})
      repeat (50) @(posedge clk);
      op(8'h66);
      op(8'h99);
      `CHECK("idle reset", r0 + 2, rstCnt)
      `CHECK("no idle abort", a0 + 1, abortCnt)
   endtask

   initial begin
      repeat (2) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (10) @(posedge clk);
      testResetState();
      testTable(1'b0);
      testTable(1'b1);
      testSuspend(1'b0);
      testSuspend(1'b1);
      testSoftReset();
      summarize();
   end

   initial begin
      #200_000;
      errCount++;
      summarize();
   end
endmodule // test_flash_suspend_resume_reset_cmds
